// ---- smdac_pkg.sv ----
// Shared constants for the two-wire receive-only DAC interface.
// Assumes a single 40 MHz system clock and externally pulled-up bus wires.
package smdac_pkg;

  // ----------------------------------------------------------------
  // Addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] OWN_ADDR_PREFIX = 4'h4;
  localparam logic [6:0] SYNC_ADDR = 7'h7e;

  // ----------------------------------------------------------------
  // Command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_SYNC_ONLY_POS = 0;
  localparam int CMD_POWER_DOWN_POS = 1;
  localparam int CMD_REF_SEL_POS = 2;
  localparam logic [2:0] CMD_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Data bytes and counters
  // ----------------------------------------------------------------
  localparam int CODE_HI_MSB = 1;
  localparam int CODE_W = 10;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    SMDAC_IDLE = 3'b000,
    SMDAC_ADDR = 3'b001,
    SMDAC_CMD = 3'b010,
    SMDAC_LOW = 3'b011,
    SMDAC_HIGH = 3'b100,
    SMDAC_SKIP = 3'b101
  } smdac_state_t;

endpackage : smdac_pkg

// ---- smdac_bus_if.sv ----
// Bus events passed from the pin sampler to the protocol engine.
// Both ends run on the same system clock; every event except the sda_lvl level is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface smdac_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic start;
  logic stop;
  modport det (output scl_rise, output scl_fall, output sda_lvl, output start, output stop);
  modport eng (input scl_rise, input scl_fall, input sda_lvl, input start, input stop);
endinterface : smdac_bus_if
`default_nettype wire

// ---- smdac_detect.sv ----
// Pin sampler: synchronises SCL and SDA and finds edges, start and stop.
// Assumes both pins are asynchronous to i_clk and change slowly against it.
`timescale 1ns/1ps
`default_nettype none
module smdac_detect (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  smdac_bus_if.det bus
);

  // ----------------------------------------------------------------
  // Synchronisers and history
  // ----------------------------------------------------------------
  // Index 0 is the metastable stage; only index 1 reads it
  logic [2:0] scl_q, scl_d;
  logic [2:0] sda_q, sda_d;

  always_comb begin
    scl_d = {scl_q[1:0], i_scl};
    sda_d = {sda_q[1:0], i_sda};
  end

  // Idle bus is high, so reset to ones to avoid a false SCL rise or stop
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  assign bus.scl_rise = scl_q[1] & ~scl_q[2];
  assign bus.scl_fall = ~scl_q[1] & scl_q[2];
  assign bus.sda_lvl = sda_q[1];
  assign bus.start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign bus.stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

endmodule : smdac_detect
`default_nettype wire

// ---- smdac_top.sv ----
// Receive-only two-wire slave for a 10-bit DAC: address, command and data
// bytes, stop-time update, power-down and the shared sync quick command.
// Assumes an external master drives SCL; SDA is open drain with pull-up.
`timescale 1ns/1ps
`default_nettype none
module smdac_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_addr_sel,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [9:0] o_dac_code,
  output logic o_power_down,
  output logic o_ref_internal
);

  smdac_bus_if bus ();

  smdac_detect u_detect (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .bus(bus)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smdac_pkg::smdac_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic ack_phase_q, ack_phase_d;
  logic sda_oe_q, sda_oe_d;
  logic is_sync_q, is_sync_d;
  logic active_q, active_d;
  logic cmd_seen_q, cmd_seen_d;
  logic [2:0] cmd_q, cmd_d;
  logic [7:0] low_tmp_q, low_tmp_d;
  logic [9:0] in_code_q, in_code_d;
  logic [9:0] code_q, code_d;
  logic pd_q, pd_d;
  logic ref_q, ref_d;
  logic [2:0] sel_meta_q, sel_q;

  logic [6:0] own_addr;
  logic own_hit;
  logic sync_hit;

  assign own_addr = {smdac_pkg::OWN_ADDR_PREFIX, sel_q};
  assign own_hit = (shift_q[7:1] == own_addr) && !shift_q[0];
  assign sync_hit = (shift_q[7:1] == smdac_pkg::SYNC_ADDR);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ack_phase_d = ack_phase_q;
    sda_oe_d = sda_oe_q;
    is_sync_d = is_sync_q;
    active_d = active_q;
    cmd_seen_d = cmd_seen_q;
    cmd_d = cmd_q;
    low_tmp_d = low_tmp_q;
    in_code_d = in_code_q;
    code_d = code_q;
    pd_d = pd_q;
    ref_d = ref_q;
    if (bus.stop) begin
      if (active_q && !cmd_q[smdac_pkg::CMD_SYNC_ONLY_POS]) begin
        code_d = in_code_q;
      end
      if (cmd_seen_q) begin
        pd_d = cmd_q[smdac_pkg::CMD_POWER_DOWN_POS];
        ref_d = cmd_q[smdac_pkg::CMD_REF_SEL_POS];
      end
      state_d = smdac_pkg::SMDAC_IDLE;
      cnt_d = smdac_pkg::CNT_ZERO;
      ack_phase_d = 1'b0;
      sda_oe_d = 1'b0;
      active_d = 1'b0;
      cmd_seen_d = 1'b0;
    end else if (bus.start) begin
      // Repeated start abandons any unfinished byte
      state_d = smdac_pkg::SMDAC_ADDR;
      cnt_d = smdac_pkg::CNT_ZERO;
      ack_phase_d = 1'b0;
      sda_oe_d = 1'b0;
    end else if (bus.scl_fall) begin
      if (ack_phase_q) begin
        ack_phase_d = 1'b0;
        sda_oe_d = 1'b0;
      end else if (cnt_q == smdac_pkg::BYTE_BITS && state_q != smdac_pkg::SMDAC_SKIP
                   && state_q != smdac_pkg::SMDAC_IDLE) begin
        cnt_d = smdac_pkg::CNT_ZERO;
        ack_phase_d = 1'b1;
        if (state_q == smdac_pkg::SMDAC_ADDR) begin
          is_sync_d = sync_hit;
          // Acknowledge only own or sync address
          sda_oe_d = own_hit || sync_hit;
          if (!(own_hit || sync_hit)) begin
            state_d = smdac_pkg::SMDAC_SKIP;
            ack_phase_d = 1'b0;
          end
        end else begin
          sda_oe_d = 1'b1;
        end
      end
    end else if (bus.scl_rise) begin
      if (ack_phase_q) begin
        unique case (state_q)
          smdac_pkg::SMDAC_ADDR: begin
            if (is_sync_q) begin
              state_d = smdac_pkg::SMDAC_SKIP;
              if (shift_q[0]) begin
                if (cmd_q[smdac_pkg::CMD_SYNC_ONLY_POS]) begin
                  code_d = in_code_q;
                end
              end else begin
                cmd_d = smdac_pkg::CMD_RESET;
                low_tmp_d = smdac_pkg::BYTE_RESET;
                in_code_d = smdac_pkg::CODE_RESET;
                code_d = smdac_pkg::CODE_RESET;
                pd_d = 1'b0;
                ref_d = 1'b0;
                cmd_seen_d = 1'b0;
              end
            end else begin
              state_d = smdac_pkg::SMDAC_CMD;
              active_d = 1'b1;
            end
          end
          smdac_pkg::SMDAC_CMD: begin
            // Command bits latched on their acknowledge
            cmd_d = {shift_q[smdac_pkg::CMD_REF_SEL_POS],
                     shift_q[smdac_pkg::CMD_POWER_DOWN_POS],
                     shift_q[smdac_pkg::CMD_SYNC_ONLY_POS]};
            cmd_seen_d = 1'b1;
            state_d = smdac_pkg::SMDAC_LOW;
          end
          smdac_pkg::SMDAC_LOW: begin
            // Low byte held until the word completes
            low_tmp_d = shift_q;
            state_d = smdac_pkg::SMDAC_HIGH;
          end
          smdac_pkg::SMDAC_HIGH: begin
            // Word complete, both bytes committed together
            in_code_d = {shift_q[smdac_pkg::CODE_HI_MSB:0], low_tmp_q};
            state_d = smdac_pkg::SMDAC_SKIP;
          end
          smdac_pkg::SMDAC_IDLE, smdac_pkg::SMDAC_SKIP: begin
            state_d = state_q;
          end
          default: begin
            state_d = smdac_pkg::SMDAC_IDLE;
          end
        endcase
      end else if (cnt_q != smdac_pkg::BYTE_BITS) begin
        shift_d = {shift_q[6:0], bus.sda_lvl};
        cnt_d = cnt_q + smdac_pkg::CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= smdac_pkg::SMDAC_IDLE;
      cnt_q <= smdac_pkg::CNT_ZERO;
      shift_q <= smdac_pkg::BYTE_RESET;
      ack_phase_q <= 1'b0;
      sda_oe_q <= 1'b0;
      is_sync_q <= 1'b0;
      active_q <= 1'b0;
      cmd_seen_q <= 1'b0;
      cmd_q <= smdac_pkg::CMD_RESET;
      low_tmp_q <= smdac_pkg::BYTE_RESET;
      in_code_q <= smdac_pkg::CODE_RESET;
      code_q <= smdac_pkg::CODE_RESET;
      pd_q <= 1'b0;
      ref_q <= 1'b0;
      sel_meta_q <= 3'h0;
      sel_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ack_phase_q <= ack_phase_d;
      sda_oe_q <= sda_oe_d;
      is_sync_q <= is_sync_d;
      active_q <= active_d;
      cmd_seen_q <= cmd_seen_d;
      cmd_q <= cmd_d;
      low_tmp_q <= low_tmp_d;
      in_code_q <= in_code_d;
      code_q <= code_d;
      pd_q <= pd_d;
      ref_q <= ref_d;
      // Address straps may move at any time, so they are synchronised too
      sel_meta_q <= i_addr_sel;
      sel_q <= sel_meta_q;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_q;
  assign o_dac_code = code_q;
  assign o_power_down = pd_q;
  assign o_ref_internal = ref_q;

endmodule : smdac_top
`default_nettype wire

// ---- smdac_top_properties.sv ----
// Pin and output checks for the DAC slave.
// Assumes the bus master runs SCL at 8 system clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module smdac_top_properties (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_addr_sel,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic [9:0] o_dac_code,
  input wire logic o_power_down,
  input wire logic o_ref_internal
);
  // ----------------
  // Assertions
  // ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_ack_hi;
    o_sda_oe && $rose(i_scl);
  endsequence
  sequence s_stop;
    i_scl && $rose(i_sda);
  endsequence
  a_drive_zero: assert property (o_sda_out == 1'b0)
    else $error("sda drive not zero");
  a_ack_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("ack raised with scl high");
  a_ack_holds: assert property (s_ack_hi |-> o_sda_oe [*5])
    else $error("ack dropped in pulse");
  a_ack_release: assert property ($fell(i_scl) && o_sda_oe |-> ##[1:5] !o_sda_oe)
    else $error("ack not released");
  a_stop_quiet: assert property (s_stop |-> !o_sda_oe [*4])
    else $error("sda held at stop");
  a_code_scl_high: assert property ($changed(o_dac_code) |-> i_scl)
    else $error("code moved with scl low");
  a_pd_at_stop: assert property ($rose(o_power_down) |-> i_scl && i_sda)
    else $error("power down not at stop");
  a_ref_scl_high: assert property ($changed(o_ref_internal) |-> i_scl)
    else $error("reference moved with scl low");
  a_reset_clear: assert property ($fell(i_sys_rst) |->
    o_dac_code == 10'h000 && !o_power_down) else $error("outputs not clear");
endmodule : smdac_top_properties
bind smdac_top smdac_top_properties smdac_top_properties_i (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda), .i_addr_sel(i_addr_sel),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_dac_code(o_dac_code),
  .o_power_down(o_power_down), .o_ref_internal(o_ref_internal));
`default_nettype wire

// ---- smdac_host.sv ----
// Bus master model driving SCL and its own SDA pull-down.
// Assumes a pull-up on SDA; tasks are entered just after an i_clk fall.
`timescale 1ns/1ps
`default_nettype none
module smdac_host (
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // ----------------
  // Framing
  // ----------------
  // SCL stands still between frames; a released SDA rests high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start_cond;
    o_sda = 1'b1;
    #50 o_scl = 1'b1;
    #100 o_sda = 1'b0;
    #100 o_scl = 1'b0;
    #50;
  endtask : start_cond
  task automatic stop_cond;
    o_sda = 1'b0;
    #50 o_scl = 1'b1;
    #100 o_sda = 1'b1;
    #100;
  endtask : stop_cond
  // msb first, ninth bit released for the ack
  task automatic put_byte(input logic [8:0] b, input int n, output logic ack);
    for (int k = 8; k > 8 - n; k--) begin
      o_sda = b[k];
      #50 o_scl = 1'b1;
      #50 ack = ~i_sda;
      #50 o_scl = 1'b0;
      #50;
    end
  endtask : put_byte
endmodule : smdac_host
`default_nettype wire

// ---- smdac_top_bench.sv ----
// Self-checking bench: the host model drives the bus.
// Assumes SDA resolves as the AND of both released drivers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module smdac_top_bench;
  logic i_clk;
  logic i_sys_rst;
  logic [2:0] addr_sel;
  logic scl;
  logic host_sda;
  logic sda_w;
  logic sda_out;
  logic sda_oe;
  logic [9:0] dac_code;
  logic power_down;
  logic ref_internal;
  int errors = 0;
  int checked = 0;
  assign sda_w = host_sda & ~sda_oe;
  smdac_top smdac_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda_w),
    .i_addr_sel(addr_sel), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_dac_code(dac_code),
    .o_power_down(power_down), .o_ref_internal(ref_internal));
  smdac_host smdac_host_i (.i_sda(sda_w), .o_scl(scl), .o_sda(host_sda));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  function automatic logic [7:0] own();
    return {4'h4, addr_sel, 1'b0};
  endfunction : own
  // Start, bytes with expected ack, optional stop
  task automatic frame(input logic [7:0] q[$], input logic e, input logic p);
    logic a;
    smdac_host_i.start_cond();
    foreach (q[k]) begin
      smdac_host_i.put_byte({q[k], 1'b1}, 9, a);
      `CHK("ack", e, a)
    end
    if (p) smdac_host_i.stop_cond();
  endtask : frame
  task automatic outs(input logic [9:0] c, input logic pd, input logic rf);
    `CHK("sda_drive", 1'b0, sda_out)
    `CHK("code", c, dac_code)
    `CHK("power_down", pd, power_down)
    `CHK("ref", rf, ref_internal)
  endtask : outs
  // Word ends in a repeated start to the sync address while stop-time update is selected
  task automatic t_word;
    frame({own(), 8'h04, 8'hA5, 8'hFE}, 1'b1, 1'b0);
    frame({8'hFD}, 1'b1, 1'b0);
    outs(10'h000, 1'b0, 1'b0);
    smdac_host_i.stop_cond();
    outs(10'h2A5, 1'b0, 1'b1);
    $display("test word done");
  endtask : t_word
  task automatic t_abort;
    logic a;
    frame({own(), 8'h02, 8'h3C}, 1'b1, 1'b0);
    outs(10'h2A5, 1'b0, 1'b1);
    smdac_host_i.stop_cond();
    outs(10'h2A5, 1'b1, 1'b0);
    frame({own()}, 1'b1, 1'b0);
    smdac_host_i.put_byte(9'h000, 7, a);
    smdac_host_i.stop_cond();
    outs(10'h2A5, 1'b1, 1'b0);
    $display("test abort done");
  endtask : t_abort
  task automatic t_sync;
    frame({own(), 8'h01}, 1'b1, 1'b1);
    outs(10'h2A5, 1'b0, 1'b0);
    frame({own(), 8'h01, 8'h0F, 8'h01}, 1'b1, 1'b1);
    outs(10'h2A5, 1'b0, 1'b0);
    frame({8'hFD}, 1'b1, 1'b0);
    outs(10'h10F, 1'b0, 1'b0);
    smdac_host_i.stop_cond();
    frame({own(), 8'h06}, 1'b1, 1'b1);
    outs(10'h10F, 1'b1, 1'b1);
    frame({8'hFC}, 1'b1, 1'b0);
    outs(10'h000, 1'b0, 1'b0);
    smdac_host_i.stop_cond();
    $display("test sync done");
  endtask : t_sync
  task automatic t_nack;
    frame({8'h44, 8'h06}, 1'b0, 1'b1);
    frame({8'h4B}, 1'b0, 1'b1);
    outs(10'h000, 1'b0, 1'b0);
    addr_sel = 3'h2;
    frame({own(), 8'h04}, 1'b1, 1'b1);
    outs(10'h000, 1'b0, 1'b1);
    $display("test address done");
  endtask : t_nack
  initial begin
    i_sys_rst = 1'b1;
    addr_sel = 3'h5;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    outs(10'h000, 1'b0, 1'b0);
    repeat (4) @(negedge i_clk);
    t_word();
    t_abort();
    t_sync();
    t_nack();
    results();
  end
  // Watchdog against a hung bus
  initial begin
    repeat (40000) @(posedge i_clk);
    errors++;
    results();
  end
endmodule : smdac_top_bench
`default_nettype wire
